// *** rtl/ovrd_pkg.sv ***
// Constants, field layouts and carrier types of the over-range detector
package ovrd_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CH = 4;
  localparam int CODE_W = 9;
  localparam int MAG_W  = 8;
  localparam int CNT_W  = 11;
  localparam int SEL_W  = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int QUIET_W = 12;

  // ==========================================================================
  // Code and magnitude limits
  localparam logic [CODE_W-1:0] CODE_MOST_NEG = 9'h100;
  localparam logic [MAG_W-1:0]  MAG_MAX       = 8'hff;

  // ==========================================================================
  // Hold length, in sample-clock cycles, for a select value of zero
  localparam logic [CNT_W-1:0] HOLD_BASE = 11'h008;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_LIVE   = 8'h10;

  // ==========================================================================
  // Control field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_SEL_LSB   = 1;
  localparam int CTRL_FGCAL_BIT = 4;
  localparam int CTRL_BGCAL_BIT = 5;
  localparam int CTRL_W         = 6;

  // Live status field positions
  localparam int LIVE_SAMPLING_BIT = 4;
  localparam int LIVE_BGCAL_BIT    = 5;

  // ==========================================================================
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h00;
  localparam logic [MAG_W-1:0]  THRESH_RST = 8'he4;
  localparam logic [NUM_CH-1:0] MASK_RST   = 4'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic                              valid;
    logic [NUM_CH-1:0][CODE_W-1:0]     code;
  } ovrd_samples_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ovrd_bus_req_t;

endpackage

// *** rtl/ovrd_top.sv ***
// Over-range detector: sample capture, per-channel hold logic and register slave
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// One channel: magnitude, compare and hold counter
module ovrd_channel (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      sample_valid,
  input  wire logic [ovrd_pkg::CODE_W-1:0] code,
  input  wire logic                      enable,
  input  wire logic [ovrd_pkg::MAG_W-1:0]  threshold,
  input  wire logic [ovrd_pkg::CNT_W-1:0]  hold_len,
  output logic                           event_hit,
  output logic                           ovr_out
);
  import ovrd_pkg::*;

  logic [MAG_W-1:0]   mag;
  logic [MAG_W:0]     neg_code;
  logic               is_neg;
  logic               qualify;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic               out_r;
  logic [QUIET_W-1:0] quiet_r;

  // Sign bit set means the negative input was the higher one
  assign is_neg   = code[CODE_W-1];
  assign neg_code = (~code) + 9'h001;
  // Negating the most negative code overflows, so clamp it
  assign mag      = !is_neg ? code[MAG_W-1:0] :
                    (code == CODE_MOST_NEG) ? MAG_MAX : neg_code[MAG_W-1:0];
  assign qualify  = enable && sample_valid && (mag >= threshold);
  assign event_hit = qualify;

  assign cnt_nxt = !enable ? '0 :
                   qualify ? hold_len :
                   (cnt_r != '0) ? cnt_r - 11'h001 : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= (cnt_nxt != '0);
    end
  end

  assign ovr_out = out_r;

  // Cycles since the last qualifying sample, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_r <= '1;
    end else if (qualify) begin
      quiet_r <= 12'h001;
    end else if (quiet_r != '1) begin
      quiet_r <= quiet_r + 12'h001;
    end
  end

  property p_rise_on_hit;
    @(posedge clk) disable iff (rst)
    qualify |=> ovr_out;
  endproperty
  a_rise_on_hit: assert property (p_rise_on_hit) else $error("output not set after hit");

  property p_restart;
    @(posedge clk) disable iff (rst)
    qualify |=> (cnt_r == $past(hold_len));
  endproperty
  a_restart: assert property (p_restart) else $error("hold count not restarted");

  property p_fall_after_len;
    @(posedge clk) disable iff (rst)
    ($fell(ovr_out) && $past(enable) && $stable(hold_len)) |-> (quiet_r == {1'b0, hold_len} + 12'h001);
  endproperty
  a_fall_after_len: assert property (p_fall_after_len) else $error("pulse length wrong");

  property p_disabled_low;
    @(posedge clk) disable iff (rst)
    !enable |=> (!ovr_out && cnt_r == '0);
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("output high while disabled");

  property p_no_spurious;
    @(posedge clk) disable iff (rst)
    (!ovr_out && !qualify) |=> !ovr_out;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("output set without hit");

  property p_neg_sat;
    @(posedge clk) disable iff (rst)
    (enable && sample_valid && code == CODE_MOST_NEG && threshold == MAG_MAX) |=> ovr_out;
  endproperty
  a_neg_sat: assert property (p_neg_sat) else $error("most negative code not saturated");

  property p_below_ignored;
    @(posedge clk) disable iff (rst)
    (sample_valid && !is_neg && code[MAG_W-1:0] < threshold) |-> !qualify;
  endproperty
  a_below_ignored: assert property (p_below_ignored) else $error("hit below threshold");

  property p_mag_mirror;
    @(posedge clk) disable iff (rst)
    (is_neg && code != CODE_MOST_NEG) |-> (MAG_W'(mag + code[MAG_W-1:0]) == '0);
  endproperty
  a_mag_mirror: assert property (p_mag_mirror) else $error("negative magnitude wrong");

  property p_hold_keeps;
    @(posedge clk) disable iff (rst)
    (enable && ovr_out && cnt_r > 11'h001) |=> ovr_out;
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("output dropped before count end");
endmodule

// ============================================================================
// Top: sample capture, register slave, status and interrupt
module ovrd_top (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESET,
  input  wire ovrd_pkg::ovrd_samples_t SAMPLE_IN,
  input  wire ovrd_pkg::ovrd_bus_req_t BUS_REQ,
  output logic [ovrd_pkg::DATA_W-1:0]  BUS_RDATA,
  output ovrd_pkg::ovrd_samples_t      SAMPLE_OUT,
  output logic                         OVERRANGE_OUT_A,
  output logic                         OVERRANGE_OUT_B,
  output logic                         OVERRANGE_OUT_C,
  output logic                         OVERRANGE_OUT_D,
  output logic                         IRQ
);
  import ovrd_pkg::*;

  // ==========================================================================
  // Registers
  logic [CTRL_W-1:0] ctrl_r;
  logic [MAG_W-1:0]  thresh_r;
  logic [NUM_CH-1:0] status_r;
  logic [NUM_CH-1:0] status_nxt;
  logic [NUM_CH-1:0] mask_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  ovrd_samples_t     samp_r;

  logic               en;
  logic               fg_cal;
  logic               bg_cal;
  logic [SEL_W-1:0]   hold_sel;
  logic [CNT_W-1:0]   hold_len;
  logic               take_sample;
  logic [NUM_CH-1:0]  hit;
  logic [NUM_CH-1:0]  ovr;
  logic               wr_ctrl;
  logic               wr_thresh;
  logic               wr_mask;
  logic               rd_status;

  // ==========================================================================
  // Decode
  assign wr_ctrl   = BUS_REQ.wr && (BUS_REQ.addr == ADDR_CTRL);
  assign wr_thresh = BUS_REQ.wr && (BUS_REQ.addr == ADDR_THRESH);
  assign wr_mask   = BUS_REQ.wr && (BUS_REQ.addr == ADDR_MASK);
  assign rd_status = BUS_REQ.rd && (BUS_REQ.addr == ADDR_STATUS);

  assign en       = ctrl_r[CTRL_EN_BIT];
  assign fg_cal   = ctrl_r[CTRL_FGCAL_BIT];
  assign bg_cal   = ctrl_r[CTRL_BGCAL_BIT];
  assign hold_sel = ctrl_r[CTRL_SEL_LSB +: SEL_W];
  assign hold_len = HOLD_BASE << hold_sel;

  // Foreground calibration takes the cores offline; background keeps converting
  assign take_sample = SAMPLE_IN.valid && !fg_cal;

  // ==========================================================================
  // Sample capture
  // Registering here adds one cycle but keeps compare paths short at full rate
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      samp_r <= '0;
    end else begin
      samp_r.valid <= take_sample;
      if (take_sample) begin
        samp_r.code <= SAMPLE_IN.code;
      end
    end
  end

  assign SAMPLE_OUT = samp_r;

  // ==========================================================================
  // Channels
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      ovrd_channel u_ch (
        .clk          (CORE_CLK),
        .rst          (RESET),
        .sample_valid (samp_r.valid),
        .code         (samp_r.code[gi]),
        .enable       (en),
        .threshold    (thresh_r),
        .hold_len     (hold_len),
        .event_hit    (hit[gi]),
        .ovr_out      (ovr[gi])
      );
    end
  endgenerate

  assign OVERRANGE_OUT_A = ovr[0];
  assign OVERRANGE_OUT_B = ovr[1];
  assign OVERRANGE_OUT_C = ovr[2];
  assign OVERRANGE_OUT_D = ovr[3];

  // ==========================================================================
  // Control registers
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_r   <= CTRL_RST;
      thresh_r <= THRESH_RST;
      mask_r   <= MASK_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= BUS_REQ.wdata[CTRL_W-1:0];
      if (wr_thresh) thresh_r <= BUS_REQ.wdata[MAG_W-1:0];
      if (wr_mask) mask_r <= BUS_REQ.wdata[NUM_CH-1:0];
    end
  end

  // ==========================================================================
  // Sticky status; a hit in the clearing read's cycle survives it
  assign status_nxt = (rd_status ? '0 : status_r) | hit;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign IRQ = |(status_r & mask_r);

  // ==========================================================================
  // Read path
  assign rdata_nxt =
    !BUS_REQ.rd                  ? '0 :
    (BUS_REQ.addr == ADDR_CTRL)   ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_r} :
    (BUS_REQ.addr == ADDR_THRESH) ? {{(DATA_W-MAG_W){1'b0}}, thresh_r} :
    (BUS_REQ.addr == ADDR_STATUS) ? {{(DATA_W-NUM_CH){1'b0}}, status_r} :
    (BUS_REQ.addr == ADDR_MASK)   ? {{(DATA_W-NUM_CH){1'b0}}, mask_r} :
    (BUS_REQ.addr == ADDR_LIVE)   ? {{(DATA_W-CTRL_W){1'b0}}, bg_cal, !fg_cal, ovr} :
    '0;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign BUS_RDATA = rdata_r;

  // ==========================================================================
  // Checks
  property p_fg_stops;
    @(posedge CORE_CLK) disable iff (RESET)
    fg_cal |=> !samp_r.valid;
  endproperty
  a_fg_stops: assert property (p_fg_stops) else $error("sample taken during foreground cal");

  property p_bg_runs;
    @(posedge CORE_CLK) disable iff (RESET)
    (SAMPLE_IN.valid && !fg_cal) |=> (samp_r.valid && samp_r.code == $past(SAMPLE_IN.code));
  endproperty
  a_bg_runs: assert property (p_bg_runs) else $error("sample not captured");

  property p_off_no_status;
    @(posedge CORE_CLK) disable iff (RESET)
    (!en && !rd_status) |=> (status_r == $past(status_r));
  endproperty
  a_off_no_status: assert property (p_off_no_status) else $error("status set while disabled");

  property p_pins_low_off;
    @(posedge CORE_CLK) disable iff (RESET)
    (!en)[*2] |-> !(OVERRANGE_OUT_A || OVERRANGE_OUT_B || OVERRANGE_OUT_C || OVERRANGE_OUT_D);
  endproperty
  a_pins_low_off: assert property (p_pins_low_off) else $error("pin high while disabled");

  property p_set_wins;
    @(posedge CORE_CLK) disable iff (RESET)
    (rd_status && hit[0]) |=> status_r[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  property p_pin_map;
    @(posedge CORE_CLK) disable iff (RESET)
    (hit != '0) |=>
      (({OVERRANGE_OUT_D, OVERRANGE_OUT_C, OVERRANGE_OUT_B, OVERRANGE_OUT_A} & $past(hit)) == $past(hit));
  endproperty
  a_pin_map: assert property (p_pin_map) else $error("hit not on its own pin");

  property p_status_sets;
    @(posedge CORE_CLK) disable iff (RESET)
    (hit != '0) |=> ((status_r & $past(hit)) == $past(hit));
  endproperty
  a_status_sets: assert property (p_status_sets) else $error("hit not recorded in status");

  property p_read_clears;
    @(posedge CORE_CLK) disable iff (RESET)
    (rd_status && hit == '0) |=> (status_r == '0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

  property p_rdata_idle;
    @(posedge CORE_CLK) disable iff (RESET)
    !BUS_REQ.rd |=> (BUS_RDATA == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read answer");

  property p_capture_hold;
    @(posedge CORE_CLK) disable iff (RESET)
    !take_sample |=> (samp_r.code == $past(samp_r.code));
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("code changed without capture");
endmodule

`default_nettype wire

// *** testbench/ovrd_gain_model.sv ***
// Downstream gain-control model watching the over-range pins
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Gain control
module ovrd_gain_model (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [3:0]              ovr,
  input  wire ovrd_pkg::ovrd_samples_t smp,
  output logic                         gain_low_r
);
  import ovrd_pkg::*;
  logic [3:0] quiet_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain_low_r <= 1'b0;
      quiet_r    <= 4'h0;
    end else if (|ovr) begin
      gain_low_r <= 1'b1;
      quiet_r    <= 4'h0;
    end else if (smp.valid) begin
      // Pins alone cannot say when to recover
      quiet_r <= quiet_r + 4'h1;
      if (&quiet_r) gain_low_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/adc_overrange_detector_bench.sv ***
// Self-checking bench of the over-range detector
`timescale 1ns/1ps
`default_nettype none
module adc_overrange_detector_bench;
  import ovrd_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  ovrd_samples_t     s_in = '0;
  ovrd_bus_req_t     req = '0;
  logic [DATA_W-1:0] rdata;
  ovrd_samples_t     s_out;
  logic [3:0]        pins;
  logic              irq;
  logic              gain_low;
  int                n_mismatch = 0;
  int                tests_run = 0;
  // ==========================================
  // Clock and instances
  initial forever #2 clk = ~clk;
  ovrd_top i_ovrd_top (.CORE_CLK(clk), .RESET(rst), .SAMPLE_IN(s_in), .BUS_REQ(req),
    .BUS_RDATA(rdata), .SAMPLE_OUT(s_out), .OVERRANGE_OUT_A(pins[0]),
    .OVERRANGE_OUT_B(pins[1]), .OVERRANGE_OUT_C(pins[2]),
    .OVERRANGE_OUT_D(pins[3]), .IRQ(irq));
  ovrd_gain_model i_ovrd_gain_model (.clk(clk), .rst(rst), .ovr(pins), .smp(s_out),
    .gain_low_r(gain_low));
  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string what);
    @(posedge clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(what, rdata, e);
  endtask
  // One sample cycle; captured copy judged one cycle later
  task automatic smp(input int ch, input logic [CODE_W-1:0] code, input logic v);
    logic [NUM_CH-1:0][CODE_W-1:0] c;
    c = '0;
    c[ch] = code;
    @(posedge clk);
    s_in <= '{1'b1, c};
    @(posedge clk);
    s_in <= '0;
    #1 chk("sample_valid", s_out.valid, v);
    if (v) chk("sample_code", s_out.code, c);
  endtask
  // Cycles a pin stays high after the last hit
  task automatic pulse(input int ch, input int exp);
    int n;
    n = 0;
    for (int i = 0; i < 1100; i++) begin
      @(posedge clk);
      #1;
      if (pins[ch] !== 1'b1) break;
      n++;
    end
    chk("pulse_len", n, exp);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(ADDR_CTRL, 32'h0, "ctrl");
    rd(ADDR_THRESH, 32'he4, "thresh");
    rd(ADDR_MASK, 32'h0, "mask");
    rd(ADDR_LIVE, 32'h10, "live");
    wr(ADDR_STATUS, 32'hf);
    rd(ADDR_STATUS, 32'h0, "status");
    wr(8'h14, 32'h1);
    rd(8'h14, 32'h0, "unmapped");
    $display("reset test done");
  endtask
  task automatic t_mag();
    logic [CODE_W-1:0] code[7] = '{9'h0ff, 9'h100, 9'h0fe, 9'h102, 9'h102, 9'h000, 9'h001};
    logic [MAG_W-1:0]  th[7] = '{8'hff, 8'hff, 8'hff, 8'hfe, 8'hff, 8'h00, 8'h02};
    logic [6:0]        hit = 7'b0101011;
    wr(ADDR_CTRL, 32'h1);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_THRESH, {24'h0, th[i]});
      smp(i % 4, code[i], 1'b1);
      // A zero threshold also catches the zero codes of the idle channels
      rd(ADDR_STATUS, {28'h0, (th[i] == 8'h00) ? 4'hf : (4'(hit[i]) << (i % 4))}, "status");
    end
    $display("magnitude test done");
  endtask
  task automatic t_hold();
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CTRL, 32'(s * 2 + 1));
      smp(s % 4, 9'h100, 1'b1);
      pulse(s % 4, 8 << s);
    end
    wr(ADDR_CTRL, 32'h1);
    smp(1, 9'h0ff, 1'b1);
    repeat (4) @(posedge clk);
    smp(1, 9'h0ff, 1'b1);
    pulse(1, 8);
    $display("hold test done");
  endtask
  task automatic t_disable();
    wr(ADDR_CTRL, 32'hf);
    smp(2, 9'h100, 1'b1);
    repeat (20) @(posedge clk);
    #1 chk("pin_c", pins[2], 1'b1);
    wr(ADDR_CTRL, 32'he);
    repeat (2) @(posedge clk);
    #1 chk("pin_off", pins[2], 1'b0);
    rd(ADDR_STATUS, 32'hf, "status");
    smp(3, 9'h100, 1'b1);
    rd(ADDR_STATUS, 32'h0, "status_off");
    wr(ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk("pin_cleared", pins, 4'h0);
    $display("disable test done");
  endtask
  task automatic t_irq();
    wr(ADDR_MASK, 32'h2);
    rd(ADDR_MASK, 32'h2, "mask");
    smp(2, 9'h100, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk("irq_masked", irq, 1'b0);
    smp(1, 9'h100, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk("irq_set", irq, 1'b1);
    rd(ADDR_STATUS, 32'h6, "status");
    chk("irq_clear", irq, 1'b0);
    // Hit and clearing read in one cycle; the hit must survive
    @(posedge clk);
    s_in <= '{1'b1, {27'h0, 9'h100}};
    @(posedge clk);
    s_in <= '0;
    req  <= '{ADDR_STATUS, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk("status_pre", rdata, 32'h0);
    rd(ADDR_STATUS, 32'h1, "status_kept");
    $display("interrupt test done");
  endtask
  task automatic t_cal();
    repeat (12) @(posedge clk);
    wr(ADDR_CTRL, 32'h11);
    smp(0, 9'h100, 1'b0);
    rd(ADDR_STATUS, 32'h0, "status_fg");
    rd(ADDR_LIVE, 32'h0, "live_fg");
    wr(ADDR_CTRL, 32'h21);
    smp(0, 9'h100, 1'b1);
    rd(ADDR_LIVE, 32'h31, "live_bg");
    rd(ADDR_STATUS, 32'h1, "status_bg");
    chk("gain_low", gain_low, 1'b1);
    // Quiet samples below threshold let the far side restore gain
    repeat (12) @(posedge clk);
    s_in <= '{1'b1, 36'h0};
    repeat (17) @(posedge clk);
    s_in <= '0;
    @(posedge clk);
    #1 chk("gain_restored", gain_low, 1'b0);
    $display("calibration test done");
  endtask
  // ==========================================
  // Main sequence and hang guard
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mag();
    t_hold();
    t_disable();
    t_irq();
    t_cal();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
